// File: mac_tx_cfg_pkg.sv
// Constants and field layout for the transmit configuration register bank
package mac_tx_cfg_pkg;
  localparam int unsigned ADDR_W          = 11;
  localparam int unsigned DATA_W          = 32;
  localparam int unsigned LEN_W           = 16;
  localparam int unsigned IFG_W           = 8;

  localparam logic [10:0] TX_CFG_OFFSET   = 11'h408;
  localparam logic [10:0] FC_CFG_OFFSET   = 11'h40c;

  localparam int unsigned TX_RESET_BIT    = 31;
  localparam int unsigned TX_JUMBO_BIT    = 30;
  localparam int unsigned TX_FCS_BIT      = 29;
  localparam int unsigned TX_ENABLE_BIT   = 28;
  localparam int unsigned TX_VLAN_BIT     = 27;
  localparam int unsigned TX_WAN_BIT      = 26;
  localparam int unsigned TX_IFG_ADJ_BIT  = 25;
  localparam int unsigned TX_DIC_BIT      = 24;
  localparam int unsigned TX_PREAMBLE_BIT = 23;
  localparam int unsigned FC_PAUSE_BIT    = 30;
  localparam int unsigned FC_PFC_BIT      = 26;

  localparam logic [31:0] TX_CFG_MASK     = 32'h7f800000;
  localparam logic [31:0] FC_CFG_MASK     = 32'h44000000;
  localparam logic [31:0] TX_CFG_RESET    = 32'h10000000;
  localparam logic [31:0] FC_CFG_RESET    = 32'h40000000;

  localparam logic [15:0] STD_MAX_LEN     = 16'h05ee;
  localparam logic [15:0] VLAN_MAX_LEN    = 16'h05f2;
endpackage

// File: mac_tx_config_control.sv
// Transmit configuration register bank with gap-aligned activation of writes, except a soft reset, which takes effect at once
`timescale 1ns/1ps
module mac_tx_config_control
  import mac_tx_cfg_pkg::*;
(
  input  wire logic              i_clk,
  input  wire logic              i_sys_rst,
  input  wire logic [ADDR_W-1:0] i_host_addr,
  input  wire logic              i_host_wr,
  input  wire logic              i_host_rd,
  input  wire logic [DATA_W-1:0] i_host_wdata,
  output logic      [DATA_W-1:0] o_host_rdata,
  output logic                   o_host_rd_valid,
  input  wire logic              i_tx_in_frame,
  input  wire logic              i_tx_frame_start,
  input  wire logic [LEN_W-1:0]  i_tx_byte_count,
  input  wire logic [IFG_W-1:0]  i_tx_ifg_delay,
  input  wire logic              i_pause_req,
  output logic                   o_tx_path_reset,
  output logic                   o_tx_enable,
  output logic                   o_tx_jumbo_en,
  output logic                   o_tx_oversize,
  output logic                   o_tx_fcs_from_client,
  output logic                   o_tx_pad_and_fcs,
  output logic                   o_tx_vlan_en,
  output logic                   o_tx_wan_mode,
  output logic                   o_tx_ifg_adjust,
  output logic [IFG_W-1:0]       o_tx_ifg_extra,
  output logic                   o_tx_dic_en,
  output logic                   o_tx_preserve_preamble,
  output logic                   o_pause_send
);

  logic [DATA_W-1:0] tx_shadow_q;
  logic [DATA_W-1:0] tx_shadow_d;
  logic [DATA_W-1:0] fc_shadow_q;
  logic [DATA_W-1:0] fc_shadow_d;
  logic [DATA_W-1:0] tx_active_q;
  logic [DATA_W-1:0] tx_active_d;
  logic [DATA_W-1:0] fc_active_q;
  logic [DATA_W-1:0] fc_active_d;
  logic              rst_pulse_q;
  logic              rst_pulse_d;
  logic [DATA_W-1:0] rdata_q;
  logic [DATA_W-1:0] rdata_d;
  logic              rvalid_q;
  logic              rvalid_d;
  logic [IFG_W-1:0]  ifg_q;
  logic [IFG_W-1:0]  ifg_d;
  logic              oversize_q;
  logic              oversize_d;
  logic              pause_q;
  logic              pause_d;
  logic              soft_rst;
  logic              adj_eff;

  // Drop reserved bits and clear deficit idle when gap adjust is set
  function automatic logic [31:0] tx_clean(input logic [31:0] v);
    logic [31:0] r;
    r = v & TX_CFG_MASK;
    r[TX_RESET_BIT] = 1'b0;
    if (r[TX_IFG_ADJ_BIT]) begin
      r[TX_DIC_BIT] = 1'b0;
    end
    return r;
  endfunction

  // Register write, reset and activation
  always_comb begin
    tx_shadow_d = tx_shadow_q;
    fc_shadow_d = fc_shadow_q;
    tx_active_d = tx_active_q;
    fc_active_d = fc_active_q;
    rst_pulse_d = 1'b0;
    soft_rst    = 1'b0;
    if (i_host_wr && i_host_addr == TX_CFG_OFFSET) begin
      tx_shadow_d = tx_clean(i_host_wdata);
      soft_rst    = i_host_wdata[TX_RESET_BIT];
      rst_pulse_d = i_host_wdata[TX_RESET_BIT];
    end
    if (i_host_wr && i_host_addr == FC_CFG_OFFSET) begin
      fc_shadow_d = i_host_wdata & FC_CFG_MASK;
    end
    if (!i_tx_in_frame) begin
      tx_active_d = tx_shadow_d;
      fc_active_d = fc_shadow_d;
    end
    if (soft_rst) begin
      tx_shadow_d = TX_CFG_RESET;
      tx_active_d = TX_CFG_RESET;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      tx_shadow_q <= TX_CFG_RESET;
      fc_shadow_q <= FC_CFG_RESET;
      tx_active_q <= TX_CFG_RESET;
      fc_active_q <= FC_CFG_RESET;
      rst_pulse_q <= 1'b0;
    end else begin
      tx_shadow_q <= tx_shadow_d;
      fc_shadow_q <= fc_shadow_d;
      tx_active_q <= tx_active_d;
      fc_active_q <= fc_active_d;
      rst_pulse_q <= rst_pulse_d;
    end
  end

  // Read path, one cycle latency
  always_comb begin
    rdata_d  = rdata_q;
    rvalid_d = i_host_rd;
    if (i_host_rd) begin
      unique case (i_host_addr)
        TX_CFG_OFFSET: rdata_d = tx_shadow_q;
        FC_CFG_OFFSET: rdata_d = fc_shadow_q;
        default:       rdata_d = '0;
      endcase
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      rdata_q  <= '0;
      rvalid_q <= 1'b0;
    end else begin
      rdata_q  <= rdata_d;
      rvalid_q <= rvalid_d;
    end
  end

  assign adj_eff = tx_active_q[TX_IFG_ADJ_BIT] & ~tx_active_q[TX_WAN_BIT];

  // Frame-time datapath controls
  always_comb begin
    ifg_d      = ifg_q;
    oversize_d = 1'b0;
    pause_d    = 1'b0;
    if (i_tx_frame_start) begin
      ifg_d = adj_eff ? i_tx_ifg_delay : '0;
    end
    if (!adj_eff) begin
      ifg_d = '0;
    end
    if (!tx_active_q[TX_JUMBO_BIT] && i_tx_in_frame) begin
      if (tx_active_q[TX_VLAN_BIT]) begin
        oversize_d = i_tx_byte_count > VLAN_MAX_LEN;
      end else begin
        oversize_d = i_tx_byte_count > STD_MAX_LEN;
      end
    end
    pause_d = i_pause_req & fc_active_q[FC_PAUSE_BIT] & tx_active_q[TX_ENABLE_BIT];
    if (soft_rst) begin
      ifg_d      = '0;
      oversize_d = 1'b0;
      pause_d    = 1'b0;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      ifg_q      <= '0;
      oversize_q <= 1'b0;
      pause_q    <= 1'b0;
    end else begin
      ifg_q      <= ifg_d;
      oversize_q <= oversize_d;
      pause_q    <= pause_d;
    end
  end

  assign o_host_rdata           = rdata_q;
  assign o_host_rd_valid        = rvalid_q;
  assign o_tx_path_reset        = rst_pulse_q;
  assign o_tx_enable            = tx_active_q[TX_ENABLE_BIT];
  assign o_tx_jumbo_en          = tx_active_q[TX_JUMBO_BIT];
  assign o_tx_oversize          = oversize_q;
  assign o_tx_fcs_from_client   = tx_active_q[TX_FCS_BIT];
  assign o_tx_pad_and_fcs       = ~tx_active_q[TX_FCS_BIT];
  assign o_tx_vlan_en           = tx_active_q[TX_VLAN_BIT];
  assign o_tx_wan_mode          = tx_active_q[TX_WAN_BIT];
  assign o_tx_ifg_adjust        = adj_eff;
  assign o_tx_ifg_extra         = ifg_q;
  assign o_tx_dic_en            = tx_active_q[TX_DIC_BIT] & ~tx_active_q[TX_IFG_ADJ_BIT];
  assign o_tx_preserve_preamble = tx_active_q[TX_PREAMBLE_BIT];
  assign o_pause_send           = pause_q;

endmodule

// File: mac_tx_cfg_assertions.sv
// Port checks for the transmit configuration bank
`timescale 1ns/1ps
module mac_tx_cfg_assertions
  import mac_tx_cfg_pkg::*;
(
  input wire logic              i_clk, i_sys_rst, i_host_wr, i_host_rd, i_tx_in_frame, i_tx_frame_start, i_pause_req,
  input wire logic [ADDR_W-1:0] i_host_addr,
  input wire logic [DATA_W-1:0] i_host_wdata,
  input wire logic [LEN_W-1:0]  i_tx_byte_count,
  input wire logic [IFG_W-1:0]  i_tx_ifg_delay, o_tx_ifg_extra,
  input wire logic              o_host_rd_valid, o_tx_path_reset, o_tx_enable, o_tx_jumbo_en, o_tx_oversize,
  input wire logic              o_tx_fcs_from_client, o_tx_pad_and_fcs, o_tx_vlan_en, o_tx_wan_mode,
  input wire logic              o_tx_ifg_adjust, o_tx_dic_en, o_pause_send
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);
  wire logic rst_wr = i_host_wr && i_host_addr == TX_CFG_OFFSET && i_host_wdata[TX_RESET_BIT];
  rd_answer_a: assert property (o_host_rd_valid == $past(i_host_rd)) else $error("read answer");
  reset_pulse_a: assert property (rst_wr |=> o_tx_path_reset ##1 !o_tx_path_reset) else $error("reset pulse");
  reset_defaults_a: assert property (o_tx_path_reset |-> o_tx_enable && !o_tx_wan_mode
    && !o_tx_jumbo_en && !o_tx_vlan_en) else $error("reset defaults");
  fcs_mode_a: assert property (o_tx_pad_and_fcs != o_tx_fcs_from_client) else $error("fcs mode");
  gap_gate_a: assert property (o_tx_ifg_adjust |-> !o_tx_dic_en && !o_tx_wan_mode) else $error("gap gate");
  frame_hold_a: assert property ($past(i_tx_in_frame) && !$past(rst_wr) |->
    $stable({o_tx_enable, o_tx_jumbo_en, o_tx_wan_mode, o_tx_vlan_en, o_tx_dic_en})) else $error("mid-frame change");
  oversize_a: assert property (o_tx_oversize == $past(i_tx_in_frame && !o_tx_jumbo_en && !rst_wr &&
    i_tx_byte_count > (o_tx_vlan_en ? VLAN_MAX_LEN : STD_MAX_LEN))) else $error("oversize");
  ifg_take_a: assert property (i_tx_frame_start && o_tx_ifg_adjust && !rst_wr |=>
    o_tx_ifg_extra == $past(i_tx_ifg_delay)) else $error("gap sample");
  pause_gate_a: assert property (o_pause_send |-> $past(i_pause_req && o_tx_enable)) else $error("pause");
endmodule
bind mac_tx_config_control mac_tx_cfg_assertions chk (.*);

// File: tx_client_model.sv
// Transmit client model giving frame timing and byte count
`timescale 1ns/1ps
module tx_client_model (
  input  wire logic        i_clk,
  input  wire logic        i_go,
  input  wire logic [15:0] i_len,
  output logic             o_in_frame = 1'h0,
  output logic             o_start = 1'h0,
  output logic [15:0]      o_count = 16'h0000
);
  always @(negedge i_clk) begin
    o_start <= 1'h0;
    if (i_go && !o_in_frame) begin
      o_in_frame <= 1'h1;
      o_start <= 1'h1;
      o_count <= 16'h0008;
    end else if (o_in_frame) begin
      o_in_frame <= o_count < i_len;
      o_count <= o_count + 16'h0008;
    end else begin
      o_count <= ~o_count;
    end
  end
endmodule

// File: mac_tx_config_control_tb.sv
// Self-checking bench for the transmit configuration bank
`timescale 1ns/1ps
`define CHK(a, e) begin checks_done++; if ((a) !== (e)) begin miscompares++; $display("BAD %0t %h %h", $time, a, e); end end
module mac_tx_config_control_tb;
  import mac_tx_cfg_pkg::*;
  logic        i_clk = 1'h0, i_sys_rst = 1'h1, i_host_wr = 1'h0, i_host_rd = 1'h0, i_pause_req = 1'h0, go = 1'h0;
  logic [10:0] i_host_addr = 11'h000;
  logic [31:0] i_host_wdata = 32'h00000000, o_host_rdata, r;
  logic [15:0] len = 16'h0040, i_tx_byte_count;
  logic [7:0]  i_tx_ifg_delay = 8'h00, o_tx_ifg_extra;
  logic        o_host_rd_valid, i_tx_in_frame, i_tx_frame_start, o_tx_path_reset, o_tx_enable, o_tx_jumbo_en, seen;
  logic        o_tx_oversize, o_tx_fcs_from_client, o_tx_pad_and_fcs, o_tx_vlan_en, o_tx_wan_mode, o_tx_ifg_adjust;
  logic        o_tx_dic_en, o_tx_preserve_preamble, o_pause_send;
  int          miscompares = 0;
  int          checks_done = 0;
  always #5 i_clk = ~i_clk;
  mac_tx_config_control uut (.*);
  tx_client_model cl (.i_clk(i_clk), .i_go(go), .i_len(len), .o_in_frame(i_tx_in_frame),
    .o_start(i_tx_frame_start), .o_count(i_tx_byte_count));
  task automatic wr(input logic [10:0] a, input logic [31:0] d);
    @(negedge i_clk);
    i_host_addr = a;
    i_host_wdata = d;
    i_host_wr = 1'h1;
    @(negedge i_clk);
    i_host_wr = 1'h0;
  endtask
  task automatic rd(input logic [10:0] a);
    @(negedge i_clk);
    i_host_addr = a;
    i_host_rd = 1'h1;
    @(negedge i_clk);
    i_host_rd = 1'h0;
    r = o_host_rdata;
    `CHK(o_host_rd_valid, 1'h1)
  endtask
  task automatic frame(input logic [15:0] l);
    @(negedge i_clk);
    len = l;
    go <= 1'h1;
    @(negedge i_clk);
    go <= 1'h0;
    @(negedge i_clk);
  endtask
  task automatic idle();
    seen = 1'h0;
    for (int n = 0; n < 400 && i_tx_in_frame; n++) begin
      @(negedge i_clk);
      seen |= o_tx_oversize;
    end
    if (i_tx_in_frame) begin
      miscompares++;
      results();
    end
    @(negedge i_clk);
  endtask
  task automatic t_fields();
    rd(TX_CFG_OFFSET);
    `CHK(r, 32'h10000000)
    rd(FC_CFG_OFFSET);
    `CHK(r, 32'h40000000)
    wr(TX_CFG_OFFSET, 32'h7fffffff);
    rd(TX_CFG_OFFSET);
    `CHK(r, 32'h7e800000)
    `CHK({o_tx_jumbo_en, o_tx_fcs_from_client, o_tx_pad_and_fcs, o_tx_vlan_en}, 4'hd)
    `CHK({o_tx_wan_mode, o_tx_ifg_adjust, o_tx_dic_en, o_tx_preserve_preamble}, 4'h9)
    rd(11'h410);
    `CHK(r, 32'h00000000)
  endtask
  task automatic t_ifg();
    i_tx_ifg_delay = 8'h2c;
    wr(TX_CFG_OFFSET, 32'h12000000);
    frame(16'h0040);
    idle();
    `CHK(o_tx_ifg_extra, 8'h2c)
    wr(TX_CFG_OFFSET, 32'h11000000);
    `CHK({o_tx_ifg_adjust, o_tx_dic_en, o_tx_pad_and_fcs}, 3'h3)
  endtask
  task automatic t_oversize();
    frame(16'h05f8);
    idle();
    `CHK(seen, 1'h1)
    wr(TX_CFG_OFFSET, 32'h58000000);
    frame(16'h05f8);
    idle();
    `CHK(seen, 1'h0)
    wr(TX_CFG_OFFSET, 32'h18000000);
    frame(16'h05f0);
    idle();
    `CHK(seen, 1'h0)
  endtask
  task automatic t_pause();
    i_pause_req = 1'h1;
    repeat (2) @(negedge i_clk);
    `CHK(o_pause_send, 1'h1)
    wr(FC_CFG_OFFSET, 32'h00000000);
    @(negedge i_clk);
    `CHK(o_pause_send, 1'h0)
    wr(FC_CFG_OFFSET, 32'h40000000);
    wr(TX_CFG_OFFSET, 32'h00000000);
    @(negedge i_clk);
    `CHK({o_tx_enable, o_pause_send}, 2'h0)
    i_pause_req = 1'h0;
  endtask
  task automatic t_gap_reset();
    frame(16'h0040);
    wr(TX_CFG_OFFSET, 32'h14000000);
    `CHK(o_tx_wan_mode, 1'h0)
    idle();
    `CHK(o_tx_wan_mode, 1'h1)
    frame(16'h0040);
    wr(TX_CFG_OFFSET, 32'h80000000);
    `CHK({o_tx_path_reset, o_tx_enable, o_tx_wan_mode}, 3'h6)
    @(negedge i_clk);
    `CHK(o_tx_path_reset, 1'h0)
    idle();
    rd(TX_CFG_OFFSET);
    `CHK(r, 32'h10000000)
  endtask
  task automatic results();
    if (miscompares == 0 && checks_done > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  initial begin
    repeat (6) @(negedge i_clk);
    i_sys_rst = 1'h0;
    t_fields();
    t_ifg();
    t_oversize();
    t_pause();
    t_gap_reset();
    results();
  end
endmodule
